/* design/plv_pkg.sv */
// plv_pkg: constants shared by the per-port lookup, vlan and spanning-tree control bank
// assumes a 16-bit register address whose top nibble carries the port number 1..6
package plv_pkg;

  // ****************************************
  // geometry
  // ****************************************
  localparam int PLV_NUM_PORTS = 6;
  localparam int PLV_NUM_INST = 8;
  localparam int PLV_AW = 16;
  localparam int PLV_DW = 8;
  localparam int PLV_VID_W = 12;

  // ****************************************
  // register offsets within a port page (low 12 bits of the address)
  // ****************************************
  localparam logic [11:0] PLV_OFF_LOOKUP_CTRL = 12'hB00;
  localparam logic [11:0] PLV_OFF_INST_PTR = 12'hB01;
  localparam logic [11:0] PLV_OFF_INST_STATE = 12'hB04;
  localparam logic [3:0] PLV_PORT_FIRST = 4'h1;
  localparam logic [3:0] PLV_PORT_LAST = 4'h6;

  // ****************************************
  // port_lookup_control fields
  // ****************************************
  localparam int PLV_CTL_NULL_VID = 7;
  localparam int PLV_CTL_INGR_FILT = 6;
  localparam int PLV_CTL_DROP_NON_PVID = 5;
  localparam int PLV_CTL_MAC_AUTH = 4;
  localparam int PLV_CTL_SA_FILT = 3;
  localparam logic [7:0] PLV_CTL_WMASK = 8'hFA; // bits 2 and 0 are read-only zero
  localparam logic [7:0] PLV_CTL_RESET = 8'h00;

  // ****************************************
  // port_stp_instance_pointer fields
  // ****************************************
  localparam int PLV_PTR_LSB = 0;
  localparam int PLV_PTR_W = 3;
  localparam logic [7:0] PLV_PTR_RESET = 8'h00;

  // ****************************************
  // port_stp_instance_state fields
  // ****************************************
  localparam int PLV_ST_TX_EN = 2;
  localparam int PLV_ST_RX_EN = 1;
  localparam int PLV_ST_LEARN_DIS = 0;
  localparam int PLV_ST_W = 3;
  localparam logic [2:0] PLV_ST_RESET = 3'h6; // tx on, rx on, learning on

  // answer on an unmapped address
  localparam logic [7:0] PLV_RD_UNMAPPED = 8'h00;

endpackage

/* design/plv_port_lookup_ctrl.sv */
// plv_port_lookup_ctrl: per-port lookup control, vlan ingress checks and spanning-tree state
// assumes all inputs come from logic on clk; the vlan membership and default vid of the
// receiving port are supplied by the lookup engine beside each request
//
// Added by the designer: the placing of the registers and the plain strobed port.
`timescale 1ns/100ps

module plv_port_lookup_ctrl
  import plv_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  // register port
  input wire logic [PLV_AW-1:0] reg_addr,
  input wire logic [PLV_DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [PLV_DW-1:0] reg_rdata,
  // global settings held elsewhere in the switch
  input wire logic sa_filter_global_en,
  input wire logic [47:0] switch_mac,
  // lookup request, one cycle
  input wire logic lk_start,
  input wire logic [2:0] lk_port,
  input wire logic [2:0] lk_inst,
  input wire logic lk_tagged,
  input wire logic [PLV_VID_W-1:0] lk_vid,
  input wire logic [PLV_VID_W-1:0] lk_pvid,
  input wire logic [PLV_NUM_PORTS-1:0] lk_vlan_member,
  input wire logic [47:0] lk_sa,
  // lookup answer, one cycle after the request
  output logic lk_done,
  output logic [PLV_VID_W-1:0] lk_table_vid,
  output logic lk_discard,
  output logic lk_mac_auth_en,
  output logic lk_learn_dis,
  // egress transmit gates for the instance named on eg_inst
  input wire logic [2:0] eg_inst,
  output logic [PLV_NUM_PORTS-1:0] port_tx_en
);

  // ****************************************
  // storage and decode
  // ****************************************
  logic [PLV_DW-1:0] lookup_ctrl [PLV_NUM_PORTS];
  logic [PLV_DW-1:0] inst_ptr [PLV_NUM_PORTS];
  logic [PLV_ST_W-1:0] inst_state [PLV_NUM_PORTS][PLV_NUM_INST];
  logic port_hit;
  logic [2:0] port_sel;
  logic [PLV_PTR_W-1:0] sel_inst;

  // port page from the top nibble; pages 1..6 map to index 0..5
  function automatic logic [2:0] plv_port_index(input logic [PLV_AW-1:0] addr);
    logic [3:0] nib;
    nib = addr[PLV_AW-1 -: 4];
    return 3'(nib - PLV_PORT_FIRST);
  endfunction

  function automatic logic plv_port_valid(input logic [PLV_AW-1:0] addr);
    logic [3:0] nib;
    nib = addr[PLV_AW-1 -: 4];
    return (nib >= PLV_PORT_FIRST) && (nib <= PLV_PORT_LAST);
  endfunction

  assign port_hit = plv_port_valid(reg_addr);
  assign port_sel = plv_port_index(reg_addr);
  assign sel_inst = inst_ptr[port_sel][PLV_PTR_LSB +: PLV_PTR_W];

  // ****************************************
  // register writes
  // ****************************************
  // control byte; bits 2 and 0 never store, so they read back zero
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int p = 0; p < PLV_NUM_PORTS; p++) begin
        lookup_ctrl[p] <= PLV_CTL_RESET;
      end
    end else if (reg_wr && port_hit && reg_addr[11:0] == PLV_OFF_LOOKUP_CTRL) begin
      lookup_ctrl[port_sel] <= reg_wdata & PLV_CTL_WMASK;
    end
  end

  // pointer byte; upper bits are plain storage, low three pick the instance
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int p = 0; p < PLV_NUM_PORTS; p++) begin
        inst_ptr[p] <= PLV_PTR_RESET;
      end
    end else if (reg_wr && port_hit && reg_addr[11:0] == PLV_OFF_INST_PTR) begin
      inst_ptr[port_sel] <= reg_wdata;
    end
  end

  // per-instance state; only the instance named by the pointer is touched
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int p = 0; p < PLV_NUM_PORTS; p++) begin
        for (int i = 0; i < PLV_NUM_INST; i++) begin
          inst_state[p][i] <= PLV_ST_RESET;
        end
      end
    end else if (reg_wr && port_hit && reg_addr[11:0] == PLV_OFF_INST_STATE) begin
      inst_state[port_sel][sel_inst] <= reg_wdata[PLV_ST_W-1:0];
    end
  end

  // ****************************************
  // register reads
  // ****************************************
  // data stand only in the cycle after the strobe; unmapped reads answer zero
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd && port_hit) begin
      unique case (reg_addr[11:0])
        PLV_OFF_LOOKUP_CTRL: reg_rdata <= lookup_ctrl[port_sel];
        PLV_OFF_INST_PTR: reg_rdata <= inst_ptr[port_sel];
        PLV_OFF_INST_STATE: reg_rdata <= {5'h00, inst_state[port_sel][sel_inst]};
        default: reg_rdata <= PLV_RD_UNMAPPED;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // ****************************************
  // lookup decision
  // ****************************************
  // settings are sampled when the request arrives: a write in that same cycle lands at the
  // edge and only affects later requests, so a frame never sees a half-applied setting
  logic [7:0] req_ctrl;
  logic [2:0] req_state;
  logic [PLV_VID_W-1:0] next_table_vid;
  logic next_discard;
  logic sa_filter_on;
  logic vlan_miss;
  logic pvid_miss;
  logic self_hit;

  // a port index above five has no registers behind it; the engine never sends one
  always_comb begin
    req_ctrl = lookup_ctrl[lk_port];
    req_state = inst_state[lk_port][lk_inst];
    // vid zero on a tagged frame keeps zero only in non-standard mode
    if (lk_tagged && lk_vid != '0) begin
      next_table_vid = lk_vid;
    end else if (lk_tagged && req_ctrl[PLV_CTL_NULL_VID]) begin
      next_table_vid = '0;
    end else begin
      next_table_vid = lk_pvid;
    end
    vlan_miss = req_ctrl[PLV_CTL_INGR_FILT] && !lk_vlan_member[lk_port];
    pvid_miss = req_ctrl[PLV_CTL_DROP_NON_PVID] && lk_tagged && lk_vid != lk_pvid;
    sa_filter_on = req_ctrl[PLV_CTL_SA_FILT] && sa_filter_global_en;
    self_hit = sa_filter_on && lk_sa == switch_mac;
    next_discard = vlan_miss || pvid_miss || self_hit || !req_state[PLV_ST_RX_EN];
  end

  // answer registers, one cycle after the request
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      lk_done <= 1'b0;
      lk_table_vid <= '0;
      lk_discard <= 1'b0;
      lk_mac_auth_en <= 1'b0;
      lk_learn_dis <= 1'b0;
    end else begin
      lk_done <= lk_start;
      if (lk_start) begin
        lk_table_vid <= next_table_vid;
        lk_discard <= next_discard;
        lk_mac_auth_en <= req_ctrl[PLV_CTL_MAC_AUTH];
        lk_learn_dis <= req_state[PLV_ST_LEARN_DIS];
      end
    end
  end

  // egress gates for all ports at the requested instance
  // a wide read of every port, traded for gates that trail eg_inst by exactly one cycle
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      port_tx_en <= '0;
    end else begin
      for (int p = 0; p < PLV_NUM_PORTS; p++) begin
        port_tx_en[p] <= inst_state[p][eg_inst][PLV_ST_TX_EN];
      end
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  logic ptr_hit_q;

  // a state read in the previous cycle, so its data stand now for the reserved-bit check
  // the checks watch registers, so each fires one edge after its cause
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ptr_hit_q <= 1'b0;
    end else begin
      ptr_hit_q <= reg_rd && port_hit && reg_addr[11:0] == PLV_OFF_INST_STATE;
    end
  end

  sequence s_state_write;
    reg_wr && port_hit && reg_addr[11:0] == PLV_OFF_INST_STATE;
  endsequence

  sequence s_state_read_back(logic [2:0] v);
    reg_rd && port_hit && reg_addr[11:0] == PLV_OFF_INST_STATE ##1 reg_rdata[2:0] == v;
  endsequence

  sequence s_lookup_req;
    lk_start;
  endsequence

  AST_NULL_VID: assert property (
    lk_start && lk_tagged && lk_vid == '0 |=>
      lk_table_vid == ($past(req_ctrl[PLV_CTL_NULL_VID]) ? '0 : $past(lk_pvid)))
    else $error("table vid for a null-vid frame is wrong");

  AST_INGRESS_FILTER: assert property (
    lk_start && req_ctrl[PLV_CTL_INGR_FILT] && !lk_vlan_member[lk_port] |=> lk_discard)
    else $error("non-member frame was not discarded");

  AST_NON_PVID: assert property (
    lk_start && req_ctrl[PLV_CTL_DROP_NON_PVID] && lk_tagged && lk_vid != lk_pvid
      |=> lk_done && lk_discard)
    else $error("frame with foreign vid was not discarded");

  AST_MAC_AUTH: assert property (
    s_lookup_req |=> lk_mac_auth_en == $past(lookup_ctrl[lk_port][PLV_CTL_MAC_AUTH]))
    else $error("mac authentication flag does not follow the port setting");

  AST_SELF_ADDR: assert property (
    lk_start && sa_filter_on && lk_sa == switch_mac |=> lk_discard)
    else $error("frame from the switch address was not dropped");

  AST_SA_GLOBAL: assert property (
    lk_start && !sa_filter_global_en && !vlan_miss && !pvid_miss && req_state[PLV_ST_RX_EN]
      |=> !lk_discard)
    else $error("frame dropped although the global self filter is off");

  AST_PTR_SELECT: assert property (
    reg_wr && port_hit && reg_addr[11:0] == PLV_OFF_INST_PTR
      |=> inst_ptr[$past(port_sel)][2:0] == $past(reg_wdata[2:0]))
    else $error("instance pointer did not take the written value");

  AST_STATE_INDEX: assert property (
    s_state_write ##1 (reg_rd && reg_addr == $past(reg_addr) && !reg_wr &&
      sel_inst == $past(sel_inst)) |=> reg_rdata[2:0] == $past(reg_wdata[2:0], 2))
    else $error("state read back does not match the selected instance");

  AST_RX_GATE: assert property (
    lk_start && !inst_state[lk_port][lk_inst][PLV_ST_RX_EN] |=> lk_discard)
    else $error("frame accepted on a port with reception off");

  AST_TX_GATE: assert property (
    !$past(sys_rst) |-> port_tx_en[0] == $past(inst_state[0][eg_inst][PLV_ST_TX_EN]))
    else $error("transmit gate does not follow the instance state");

  AST_TX_GATE_LAST: assert property (
    !$past(sys_rst) |-> port_tx_en[PLV_NUM_PORTS-1] ==
      $past(inst_state[PLV_NUM_PORTS-1][eg_inst][PLV_ST_TX_EN]))
    else $error("transmit gate of the last port does not follow the instance state");

  AST_LEARN: assert property (
    s_lookup_req |=> lk_done && lk_learn_dis == $past(req_state[PLV_ST_LEARN_DIS]))
    else $error("learning disable does not follow the instance state");

  AST_STATE_ISOLATE: assert property (
    s_state_write |=> inst_state[$past(port_sel)][3'($past(sel_inst) + 3'd1)] ==
      $past(inst_state[port_sel][3'(sel_inst + 3'd1)]))
    else $error("state write reached an instance other than the selected one");

  AST_CTRL_HOLD: assert property (
    !reg_wr |=> $stable(lookup_ctrl[0]))
    else $error("control byte changed without a write");

  AST_CTRL_MASK: assert property (
    reg_wr && port_hit && reg_addr[11:0] == PLV_OFF_LOOKUP_CTRL
      |=> lookup_ctrl[$past(port_sel)] == ($past(reg_wdata) & PLV_CTL_WMASK))
    else $error("control write stored a read-only bit");

  AST_RESERVED_ZERO: assert property (
    ##1 (reg_rdata[7:3] == 5'h00 || !ptr_hit_q) &&
      (lookup_ctrl[0] & ~PLV_CTL_WMASK) == 8'h00 &&
      (lookup_ctrl[2] & ~PLV_CTL_WMASK) == 8'h00)
    else $error("reserved read-only bits are not zero");

endmodule

/* dv/plv_port_lookup_ctrl_tb_top.sv */
// plv_port_lookup_ctrl_tb_top: self-checking bench for the per-port lookup control bank
// assumes the register port answers reads one cycle later and lookups answer one cycle later
`timescale 1ns/100ps

module plv_port_lookup_ctrl_tb_top;
  import plv_pkg::*;

  // ****************************************
  // stimulus and observed signals
  // ****************************************
  localparam logic [47:0] SW_MAC = 48'h0A1B2C3D4E5F; // arbitrary switch address
  localparam int LIMIT = 4000; // tests need well under 1000 cycles
  logic clk, sys_rst, reg_wr, reg_rd, sa_filter_global_en, lk_start, lk_tagged;
  logic [15:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata;
  logic [2:0] lk_port, lk_inst, eg_inst;
  logic [11:0] lk_vid, lk_pvid, lk_table_vid;
  logic [5:0] lk_vlan_member, port_tx_en;
  logic [47:0] lk_sa;
  logic lk_done, lk_discard, lk_mac_auth_en, lk_learn_dis;
  int bad_count, num_checks, cyc;

  plv_port_lookup_ctrl plv_port_lookup_ctrl_i (.clk(clk), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .sa_filter_global_en(sa_filter_global_en), .switch_mac(SW_MAC),
    .lk_start(lk_start), .lk_port(lk_port), .lk_inst(lk_inst), .lk_tagged(lk_tagged),
    .lk_vid(lk_vid), .lk_pvid(lk_pvid), .lk_vlan_member(lk_vlan_member), .lk_sa(lk_sa),
    .lk_done(lk_done), .lk_table_vid(lk_table_vid), .lk_discard(lk_discard),
    .lk_mac_auth_en(lk_mac_auth_en), .lk_learn_dis(lk_learn_dis), .eg_inst(eg_inst),
    .port_tx_en(port_tx_en));

  // ****************************************
  // clock, and a cycle ceiling so a hang still ends in a verdict
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      bad_count++;
      give_verdict();
    end
  end

  // ****************************************
  // compare, bus and lookup tasks
  // ****************************************
  task automatic chk(input string n, input logic [11:0] e, input logic [11:0] g);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  function automatic logic [15:0] ad(input int p, input logic [11:0] off);
    return {p[3:0], off};
  endfunction

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // read data must stand only in the cycle after the strobe
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk("reg_rdata", {4'h0, e}, {4'h0, reg_rdata});
    @(posedge clk);
    #1 chk("reg_rdata idle", 12'h000, {4'h0, reg_rdata});
  endtask

  task automatic lk(input int p, input logic [2:0] i, input logic tg, input logic [11:0] v,
                    input logic [11:0] pv, input logic [5:0] m, input logic same_sa,
                    input logic [11:0] ev, input logic ed, input logic ea, input logic el);
    @(posedge clk);
    lk_start <= 1'b1;
    lk_port <= 3'(p - 1);
    lk_inst <= i;
    lk_tagged <= tg;
    lk_vid <= v;
    lk_pvid <= pv;
    lk_vlan_member <= m;
    lk_sa <= same_sa ? SW_MAC : ~SW_MAC;
    @(posedge clk);
    lk_start <= 1'b0;
    #1 chk("lk_done", 12'h001, {11'h0, lk_done});
    chk("lk_table_vid", ev, lk_table_vid);
    chk("lk_discard", {11'h0, ed}, {11'h0, lk_discard});
    chk("lk_mac_auth_en", {11'h0, ea}, {11'h0, lk_mac_auth_en});
    chk("lk_learn_dis", {11'h0, el}, {11'h0, lk_learn_dis});
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    {reg_wr, reg_rd, lk_start, lk_tagged, sa_filter_global_en} = 5'h00;
    {reg_addr, reg_wdata, lk_port, lk_inst, eg_inst} = '0;
    {lk_vid, lk_pvid, lk_vlan_member, lk_sa} = '0;
    {bad_count, num_checks, cyc} = '0;
    sys_rst = 1'b1;
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    // reset values and access kinds
    rd(ad(1, 12'hB00), 8'h00);
    rd(ad(6, 12'hB01), 8'h00);
    rd(ad(6, 12'hB04), 8'h06);
    chk("port_tx_en", 12'h03F, {6'h0, port_tx_en});
    wr(ad(3, 12'hB00), 8'hFF);
    rd(ad(3, 12'hB00), 8'hFA);
    wr(ad(7, 12'hB00), 8'hFF);
    rd(ad(7, 12'hB00), 8'h00);
    rd(ad(4, 12'hB00), 8'h00);
    wr(ad(2, 12'hB01), 8'hFF);
    rd(ad(2, 12'hB01), 8'hFF);
    wr(ad(2, 12'hB01), 8'h00);
    // back-to-back strobes: pointer write, state write and state read in consecutive cycles
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= ad(5, 12'hB01);
    reg_wdata <= 8'h05;
    @(posedge clk);
    reg_addr <= ad(5, 12'hB04);
    reg_wdata <= 8'h05;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk("reg_rdata", 12'h005, {4'h0, reg_rdata});
    rd(ad(5, 12'hB01), 8'h05);
    $display("test registers done");
    // each instance of port 1 keeps its own state; upper bits read zero
    for (int i = 0; i < 8; i++) begin
      wr(ad(1, 12'hB01), 8'(i));
      wr(ad(1, 12'hB04), 8'hF8 | 8'(i));
    end
    for (int i = 7; i >= 0; i--) begin
      wr(ad(1, 12'hB01), 8'(i));
      rd(ad(1, 12'hB04), 8'(i));
    end
    rd(ad(2, 12'hB04), 8'h06);
    // transmit gates follow the instance named on eg_inst
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      eg_inst <= 3'(i);
      @(posedge clk);
      @(posedge clk);
      #1 chk("port_tx_en", (i & 4) ? 12'h03F : 12'h03E, {6'h0, port_tx_en});
    end
    lk(1, 3'h0, 1'b1, 12'h009, 12'h005, 6'h3F, 1'b0, 12'h009, 1'b1, 1'b0, 1'b0);
    lk(1, 3'h3, 1'b1, 12'h009, 12'h005, 6'h3F, 1'b0, 12'h009, 1'b0, 1'b0, 1'b1);
    lk(1, 3'h6, 1'b1, 12'h009, 12'h005, 6'h3F, 1'b0, 12'h009, 1'b0, 1'b0, 1'b0);
    $display("test instances done");
    // vid choice for the vlan table, port 2 instance 0 at reset state
    lk(2, 3'h0, 1'b1, 12'h000, 12'h005, 6'h3F, 1'b0, 12'h005, 1'b0, 1'b0, 1'b0);
    lk(2, 3'h0, 1'b0, 12'h009, 12'h005, 6'h3F, 1'b0, 12'h005, 1'b0, 1'b0, 1'b0);
    wr(ad(2, 12'hB00), 8'h80);
    lk(2, 3'h0, 1'b1, 12'h000, 12'h005, 6'h3F, 1'b0, 12'h000, 1'b0, 1'b0, 1'b0);
    lk(2, 3'h0, 1'b1, 12'h009, 12'h005, 6'h3F, 1'b0, 12'h009, 1'b0, 1'b0, 1'b0);
    // ingress membership filter
    lk(2, 3'h0, 1'b1, 12'h009, 12'h005, 6'h3D, 1'b0, 12'h009, 1'b0, 1'b0, 1'b0);
    wr(ad(2, 12'hB00), 8'h40);
    lk(2, 3'h0, 1'b1, 12'h009, 12'h005, 6'h3D, 1'b0, 12'h009, 1'b1, 1'b0, 1'b0);
    lk(2, 3'h0, 1'b1, 12'h009, 12'h005, 6'h02, 1'b0, 12'h009, 1'b0, 1'b0, 1'b0);
    // non-default vid discard; untagged frames have nothing to compare
    wr(ad(2, 12'hB00), 8'h20);
    lk(2, 3'h0, 1'b1, 12'h009, 12'h005, 6'h00, 1'b0, 12'h009, 1'b1, 1'b0, 1'b0);
    lk(2, 3'h0, 1'b1, 12'h005, 12'h005, 6'h00, 1'b0, 12'h005, 1'b0, 1'b0, 1'b0);
    lk(2, 3'h0, 1'b0, 12'h009, 12'h005, 6'h00, 1'b0, 12'h005, 1'b0, 1'b0, 1'b0);
    wr(ad(2, 12'hB00), 8'h10);
    lk(2, 3'h0, 1'b1, 12'h009, 12'h005, 6'h00, 1'b0, 12'h009, 1'b0, 1'b1, 1'b0);
    lk(3, 3'h0, 1'b1, 12'h009, 12'h005, 6'h00, 1'b1, 12'h009, 1'b1, 1'b1, 1'b0);
    $display("test vlan checks done");
    // self-address filter needs both the port bit and the global enable
    wr(ad(2, 12'hB00), 8'h08);
    lk(2, 3'h0, 1'b1, 12'h009, 12'h005, 6'h00, 1'b1, 12'h009, 1'b0, 1'b0, 1'b0);
    @(posedge clk);
    sa_filter_global_en <= 1'b1;
    lk(2, 3'h0, 1'b1, 12'h009, 12'h005, 6'h00, 1'b1, 12'h009, 1'b1, 1'b0, 1'b0);
    lk(2, 3'h0, 1'b1, 12'h009, 12'h005, 6'h00, 1'b0, 12'h009, 1'b0, 1'b0, 1'b0);
    lk(4, 3'h0, 1'b1, 12'h009, 12'h005, 6'h00, 1'b1, 12'h009, 1'b0, 1'b0, 1'b0);
    $display("test self-address done");
    give_verdict();
  end
endmodule
